//--- shared/fic_pkg.sv
// constants and types for the flash interrupt and fault-injection config block
package fic_pkg;

	// ==========================================================
	// register map (index; byte address is four times the index)
	localparam int ADDR_W = 16;
	localparam logic [ADDR_W-1:0] CFG_IDX = 16'h3024;
	localparam logic [ADDR_W-1:0] FIE_IDX = 16'h3025;
	localparam logic [ADDR_W-1:0] CST_IDX = 16'h3026;
	localparam logic [ADDR_W-1:0] FST_IDX = 16'h3027;
	localparam logic [ADDR_W-1:0] CFG_ADDR = {CFG_IDX[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] FIE_ADDR = {FIE_IDX[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] CST_ADDR = {CST_IDX[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] FST_ADDR = {FST_IDX[ADDR_W-3:0], 2'b00};

	// ==========================================================
	// field positions
	localparam int CFG_CMD_EN_BIT = 7;
	localparam int CFG_SUPPRESS_BIT = 4;
	localparam int CFG_FORCE_D_BIT = 1;
	localparam int CFG_FORCE_S_BIT = 0;
	localparam int FIE_EN_D_BIT = 1;
	localparam int FIE_EN_S_BIT = 0;
	localparam int CST_DONE_BIT = 7;
	localparam int FST_D_BIT = 1;
	localparam int FST_S_BIT = 0;

	// ==========================================================
	// values after reset
	localparam logic CFG_RESET = 1'b0;
	localparam logic FIE_RESET = 1'b0;
	localparam logic CMD_DONE_RESET = 1'b1;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic single_err;
		logic double_err;
	} fic_rd_t;

	typedef struct packed {
		logic set_single;
		logic set_double;
	} fic_fault_set_t;

	typedef struct packed {
		logic cmd_en;
		logic suppress;
		logic force_d;
		logic force_s;
		logic en_d;
		logic en_s;
		logic cmd_flag;
		logic sflag;
		logic dflag;
		logic pready;
		logic pslverr;
		logic launch;
		logic irq;
		logic [31:0] prdata;
	} fic_state_t;

endpackage

//--- hdl/fic_fault_qual.sv
// qualifies array-read error reports against the forcing and suppress controls
`timescale 1ns/1ns
module fic_fault_qual (
	input fic_pkg::fic_rd_t rd,
	input wire logic suppress,
	input wire logic force_s,
	input wire logic force_d,
	output fic_pkg::fic_fault_set_t set
);

	// ==========================================================
	// event qualification
	always_comb begin
		set = '0;
		if (rd.valid) begin
			set.set_double = force_d | rd.double_err;
			set.set_single = force_s | (rd.single_err & ~suppress);
		end
	end

endmodule

//--- hdl/fic_top.sv
// apb register file, fault flags and interrupt for flash config block
`timescale 1ns/1ns
module fic_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fic_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input fic_pkg::fic_rd_t rd,
	input wire logic cmd_complete,
	output logic cmd_launch,
	output logic irq
);

	// ==========================================================
	// state and decode
	fic_pkg::fic_state_t s_q;
	fic_pkg::fic_state_t s_d;
	fic_pkg::fic_fault_set_t fset;
	logic setup;
	logic access;
	logic wr_cfg;
	logic wr_fie;
	logic wr_cst;
	logic rd_fst;
	logic [31:0] rvalue;
	logic mapped;

	function automatic logic hit(input logic [fic_pkg::ADDR_W-1:0] a,
		input logic [fic_pkg::ADDR_W-1:0] target);
		hit = (a == target);
	endfunction

	fic_fault_qual u_qual (
		.rd(rd),
		.suppress(s_q.suppress),
		.force_s(s_q.force_s),
		.force_d(s_q.force_d),
		.set(fset)
	);

	// no wait state: data is prepared in setup, ready is high in the first access cycle
	assign setup = psel & ~penable;
	assign access = psel & penable & s_q.pready;
	assign wr_cfg = access & pwrite & hit(paddr, fic_pkg::CFG_ADDR);
	assign wr_fie = access & pwrite & hit(paddr, fic_pkg::FIE_ADDR);
	assign wr_cst = access & pwrite & hit(paddr, fic_pkg::CST_ADDR);
	assign rd_fst = access & ~pwrite & hit(paddr, fic_pkg::FST_ADDR);

	// ==========================================================
	// read mux
	always_comb begin
		rvalue = '0;
		mapped = 1'b1;
		if (hit(paddr, fic_pkg::CFG_ADDR)) begin
			rvalue[fic_pkg::CFG_CMD_EN_BIT] = s_q.cmd_en;
			rvalue[fic_pkg::CFG_SUPPRESS_BIT] = s_q.suppress;
			rvalue[fic_pkg::CFG_FORCE_D_BIT] = s_q.force_d;
			rvalue[fic_pkg::CFG_FORCE_S_BIT] = s_q.force_s;
		end else if (hit(paddr, fic_pkg::FIE_ADDR)) begin
			rvalue[fic_pkg::FIE_EN_D_BIT] = s_q.en_d;
			rvalue[fic_pkg::FIE_EN_S_BIT] = s_q.en_s;
		end else if (hit(paddr, fic_pkg::CST_ADDR)) begin
			rvalue[fic_pkg::CST_DONE_BIT] = s_q.cmd_flag;
		end else if (hit(paddr, fic_pkg::FST_ADDR)) begin
			rvalue[fic_pkg::FST_D_BIT] = s_q.dflag;
			rvalue[fic_pkg::FST_S_BIT] = s_q.sflag;
		end else begin
			mapped = 1'b0;
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.launch = 1'b0;
		// bus handshake
		s_d.pready = setup;
		if (setup) begin
			s_d.prdata = pwrite ? 32'h0000_0000 : rvalue;
			s_d.pslverr = ~mapped;
		end else if (access) begin
			s_d.pslverr = 1'b0;
		end
		if (wr_cfg) begin
			s_d.cmd_en = pwdata[fic_pkg::CFG_CMD_EN_BIT];
			s_d.suppress = pwdata[fic_pkg::CFG_SUPPRESS_BIT];
			s_d.force_d = pwdata[fic_pkg::CFG_FORCE_D_BIT];
			s_d.force_s = pwdata[fic_pkg::CFG_FORCE_S_BIT];
		end
		if (wr_fie) begin
			s_d.en_d = pwdata[fic_pkg::FIE_EN_D_BIT];
			s_d.en_s = pwdata[fic_pkg::FIE_EN_S_BIT];
		end
		// write one clears flag and launches
		if (wr_cst && pwdata[fic_pkg::CST_DONE_BIT] && s_q.cmd_flag && !cmd_complete) begin
			s_d.cmd_flag = 1'b0;
			s_d.launch = 1'b1;
		end
		if (cmd_complete) begin
			s_d.cmd_flag = 1'b1;
		end
		// read clears only bits it reported, so a late event survives
		if (rd_fst) begin
			s_d.dflag = s_q.dflag & ~s_q.prdata[fic_pkg::FST_D_BIT];
			s_d.sflag = s_q.sflag & ~s_q.prdata[fic_pkg::FST_S_BIT];
		end
		if (fset.set_double) begin
			s_d.dflag = 1'b1;
		end
		if (fset.set_single) begin
			s_d.sflag = 1'b1;
		end
		// level request per flag and enable
		s_d.irq = (s_d.cmd_flag & s_d.cmd_en) | (s_d.dflag & s_d.en_d) |
			(s_d.sflag & s_d.en_s);
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.cmd_en <= fic_pkg::CFG_RESET;
			s_q.suppress <= fic_pkg::CFG_RESET;
			s_q.force_d <= fic_pkg::CFG_RESET;
			s_q.force_s <= fic_pkg::CFG_RESET;
			s_q.en_d <= fic_pkg::FIE_RESET;
			s_q.en_s <= fic_pkg::FIE_RESET;
			s_q.cmd_flag <= fic_pkg::CMD_DONE_RESET;
			s_q.sflag <= fic_pkg::FLAG_RESET;
			s_q.dflag <= fic_pkg::FLAG_RESET;
			s_q.pready <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.launch <= 1'b0;
			s_q.irq <= 1'b0;
			s_q.prdata <= fic_pkg::RDATA_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign cmd_launch = s_q.launch;
	assign irq = s_q.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence cfg_read_s;
		psel && penable && pready && !pwrite && paddr == fic_pkg::CFG_ADDR;
	endsequence

	cmd_irq_gate_a: assert property (
		s_q.cmd_flag && !s_q.cmd_en && !(s_q.sflag && s_q.en_s) &&
		!(s_q.dflag && s_q.en_d) |-> !irq)
		else $error("command-done request raised while disabled");

	cfg_reserved_a: assert property (
		cfg_read_s |-> prdata[6:5] == 2'b00 && prdata[3:2] == 2'b00 && prdata[31:8] == '0)
		else $error("reserved config bits read nonzero");

	fie_reserved_a: assert property (
		psel && penable && pready && !pwrite && paddr == fic_pkg::FIE_ADDR
		|-> prdata[31:2] == '0)
		else $error("reserved enable bits read nonzero");

	single_report_a: assert property (
		rd.valid && rd.single_err && !s_q.suppress |=> s_q.sflag)
		else $error("unsuppressed single fault not recorded");

	single_suppress_a: assert property (
		$rose(s_q.sflag) |-> $past(rd.valid) &&
		($past(s_q.force_s) || ($past(rd.single_err) && !$past(s_q.suppress))))
		else $error("single flag set without cause");

	double_force_a: assert property (
		rd.valid && s_q.force_d |=> s_q.dflag)
		else $error("forced double fault not recorded");

	double_cause_a: assert property (
		$rose(s_q.dflag) |-> $past(rd.valid) &&
		($past(s_q.force_d) || $past(rd.double_err)))
		else $error("double flag set without cause");

	single_force_a: assert property (
		rd.valid && s_q.force_s |=> s_q.sflag ##0 (irq || !s_q.en_s))
		else $error("forced single fault not recorded");

	single_cause_a: assert property (
		!s_q.force_s && !(rd.valid && rd.single_err) && !s_q.sflag |=> !s_q.sflag)
		else $error("single flag set with no error");

	force_hold_a: assert property (
		s_q.force_s && s_q.force_d && !(psel && penable && pwrite)
		|=> s_q.force_s && s_q.force_d)
		else $error("force bits cleared without a write");

	double_irq_a: assert property (
		s_q.dflag && s_q.en_d |-> irq)
		else $error("double fault request missing");

	single_irq_a: assert property (
		s_q.sflag && s_q.en_s |-> irq)
		else $error("single fault request missing");

	idle_read_a: assert property (
		!rd.valid && !rd_fst && !s_q.dflag |=> !s_q.dflag)
		else $error("double flag set with no array read");

	launch_a: assert property (
		psel && penable && pready && pwrite && paddr == fic_pkg::CST_ADDR &&
		pwdata[fic_pkg::CST_DONE_BIT] && s_q.cmd_flag && !cmd_complete
		|=> cmd_launch && !s_q.cmd_flag ##1 !cmd_launch)
		else $error("write one did not clear flag and launch");

	irq_level_a: assert property (
		!(s_q.cmd_flag && s_q.cmd_en) && !(s_q.sflag && s_q.en_s) &&
		!(s_q.dflag && s_q.en_d) |-> !irq)
		else $error("request held with no enabled flag");

	ready_timing_a: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");

	forced_single_c: cover property (rd.valid && s_q.force_s ##1 irq);
	real_double_c: cover property (rd.valid && rd.double_err && !s_q.force_d ##1 s_q.dflag);
	status_clear_c: cover property (rd_fst && s_q.sflag ##1 !s_q.sflag);
	launch_c: cover property (cmd_launch ##[1:20] s_q.cmd_flag);

endmodule

//--- bench/fic_flash_model.sv
// array read path and command sequencer stand-in for the config block
`timescale 1ns/1ns
module fic_flash_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic se,
	input wire logic de,
	input wire logic [31:0] dly,
	input wire logic cmd_launch,
	output fic_pkg::fic_rd_t rd,
	output logic cmd_complete
);
	int cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd <= '0;
			cnt <= 0;
			cmd_complete <= 1'b0;
		end else begin
			// one cpu read per go cycle
			rd.valid <= go;
			// error lines toggle outside reads, so stale values never pass
			rd.single_err <= go ? se : ~rd.single_err;
			rd.double_err <= go ? de : ~rd.double_err;
			if (cmd_launch) begin
				cnt <= dly;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
			cmd_complete <= (cnt == 1);
		end
	end
endmodule

//--- bench/testbench.sv
// self-checking bench for the flash config block
`timescale 1ns/1ns
module testbench;
	logic pclk, presetn, psel, penable, pwrite, go, se, de, cmd_complete, cmd_launch, irq;
	logic pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, r;
	fic_pkg::fic_rd_t rd;
	int dly, err_total, total_checks, cyc, n_launch, k;
	logic [7:0] m_cfg, m_fie;
	logic m_s, m_d, m_c, e;

	fic_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rd(rd), .cmd_complete(cmd_complete), .cmd_launch(cmd_launch),
		.irq(irq));
	fic_flash_model fm (.pclk(pclk), .presetn(presetn), .go(go), .se(se), .de(de),
		.dly(dly), .cmd_launch(cmd_launch), .rd(rd), .cmd_complete(cmd_complete));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// =========================================
	// checking and bus tasks
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, ex, got);
		end
	endtask

	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1, pready);
	endtask

	task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] ex);
		apb(1'b0, a, 0);
		chk(nm, ex, r);
	endtask

	function automatic logic exp_irq();
		return (m_cfg[7] & m_c) | (m_fie[1] & m_d) | (m_fie[0] & m_s);
	endfunction

	always @(posedge pclk) begin
		cyc++;
		if (cmd_launch === 1'b1) n_launch++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end

	// =========================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, go, se, de} = '0;
		paddr = '0;
		pwdata = '0;
		dly = 8;
		{m_cfg, m_fie, m_s, m_d} = '0;
		m_c = 1'b1;
		void'($urandom(32'h82D42A35));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdc("cfg", fic_pkg::CFG_ADDR, 32'h00);
		rdc("fie", fic_pkg::FIE_ADDR, 32'h00);
		rdc("cst", fic_pkg::CST_ADDR, 32'h80);
		rdc("fst", fic_pkg::FST_ADDR, 32'h00);
		rdc("unmapped", 16'h0000, 32'h00);
		chk("pslverr", 1, e);
		$display("test reset done");
		for (k = 0; k < 40; k++) begin
			m_cfg = 8'($urandom) & 8'h93;
			m_fie = 8'($urandom) & 8'h03;
			apb(1'b1, fic_pkg::CFG_ADDR, {24'($urandom), m_cfg | 8'h6C});
			apb(1'b1, fic_pkg::FIE_ADDR, {24'hFFFFFF, m_fie | 8'hFC});
			@(posedge pclk);
			go <= 1'b1;
			se <= 1'($urandom);
			de <= 1'($urandom);
			@(posedge pclk);
			go <= 1'b0;
			m_s = m_cfg[0] | (se & ~m_cfg[4]);
			m_d = m_cfg[1] | de;
			@(posedge pclk);
			@(negedge pclk);
			chk("irq", exp_irq(), irq);
			rdc("fst", fic_pkg::FST_ADDR, {m_d, m_s});
			{m_s, m_d} = '0;
			rdc("cfg", fic_pkg::CFG_ADDR, m_cfg);
			rdc("fie", fic_pkg::FIE_ADDR, m_fie);
			chk("pslverr", 0, e);
			@(negedge pclk);
			chk("irq", exp_irq(), irq);
		end
		$display("test fault injection done");
		m_cfg = 8'h80;
		m_fie = 8'h00;
		apb(1'b1, fic_pkg::CFG_ADDR, 32'h80);
		for (k = 0; k < 2; k++) begin
			dly = k ? 1 : 8;
			n_launch = 0;
			apb(1'b1, fic_pkg::CST_ADDR, 32'h80);
			m_c = 1'b0;
			if (k == 0) begin
				apb(1'b1, fic_pkg::CST_ADDR, 32'h80);
				rdc("cst", fic_pkg::CST_ADDR, 32'h00);
				chk("irq", exp_irq(), irq);
			end
			while (cmd_complete !== 1'b1 && cyc < 19000) @(posedge pclk);
			@(negedge pclk);
			m_c = 1'b1;
			chk("irq", exp_irq(), irq);
			chk("launches", 1, n_launch);
			rdc("cst", fic_pkg::CST_ADDR, 32'h80);
		end
		apb(1'b1, fic_pkg::CFG_ADDR, 32'h00);
		m_cfg = 8'h00;
		@(negedge pclk);
		chk("irq", exp_irq(), irq);
		$display("test command done");
		finish_test();
	end
endmodule
